/* File: rtcseq_pkg.sv */
// package: register map, device map, timing and types of the serial clock host sequencer
package rtcseq_pkg;

  // ----------------------------------------------------------------
  // apb register map of the sequencer
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_CFG      = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_BUF      = 8'h20;

  localparam int CFG_W          = 5;
  localparam int CFG_MON_BIT    = 0;
  localparam int CFG_AUTO_BIT   = 1;
  localparam int CFG_SUBSET_BIT = 2;
  localparam int CFG_WEN_BIT    = 3;
  localparam int CFG_DEN_BIT    = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_PWRON_BIT = 2;
  localparam int ST_FIRST_BIT = 3;

  localparam int IRQ_W        = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_INIT_BIT = 1;
  localparam int IRQ_AUTO_BIT = 2;
  localparam int IRQ_LATE_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  localparam logic [2:0] CMD_TIME_WRITE   = 3'h1;
  localparam logic [2:0] CMD_TIME_READ    = 3'h2;
  localparam logic [2:0] CMD_PERIODIC_ON  = 3'h3;
  localparam logic [2:0] CMD_ALARM_SET    = 3'h4;
  localparam logic [2:0] CMD_ALARM_CANCEL = 3'h5;

  // ----------------------------------------------------------------
  // data buffer: time bytes, then weekly and daily alarm bytes
  // ----------------------------------------------------------------
  localparam int BUF_WORDS    = 12;
  localparam int TIME_BYTES   = 7;
  localparam int SUBSET_BYTES = 5;
  localparam int ALW_BYTES    = 3;
  localparam int ALD_BYTES    = 2;
  localparam logic [3:0] BUF_TIME = 4'h0;
  localparam logic [3:0] BUF_ALW  = 4'h7;
  localparam logic [3:0] BUF_ALD  = 4'ha;

  // ----------------------------------------------------------------
  // map of the clock device
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_ADDR_SEC   = 4'h0;
  localparam logic [3:0] DEV_ADDR_ALW   = 4'h8;
  localparam logic [3:0] DEV_ADDR_ALD   = 4'hb;
  localparam logic [3:0] DEV_ADDR_CTRL1 = 4'he;
  localparam logic [3:0] DEV_ADDR_CTRL2 = 4'hf;
  localparam logic [3:0] DEV_MODE_WR    = 4'h0;
  localparam logic [3:0] DEV_MODE_RD    = 4'h4;

  localparam logic [7:0] CTRL1_PSEL_MASK  = 8'h07;
  localparam logic [7:0] CTRL1_PSEL_LVL1S = 8'h04;
  localparam int         CTRL1_WEN_BIT    = 7;
  localparam int         CTRL1_DEN_BIT    = 6;
  localparam int         CTRL1_PWRON_BIT  = 4;
  localparam logic [7:0] CTRL1_EN_MASK    = 8'hc0;
  localparam logic [7:0] CTRL2_DROP_MASK  = 8'h40;
  localparam logic [7:0] CTRL2_PIRQ_MASK  = 8'h04;
  localparam logic [7:0] ALW_CANCEL       = 8'h55;
  localparam logic [7:0] ALD_CANCEL       = 8'h56;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned POWERUP_MS     = 2000;
  localparam int unsigned POWERUP_CYC    = POWERUP_MS * (CLK_HZ / 1000);
  localparam int unsigned READ_LIMIT_MS  = 1000;
  localparam int unsigned READ_LIMIT_CYC = READ_LIMIT_MS * (CLK_HZ / 1000);
  localparam int          SCLK_HALF_CYC  = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_BUF, SRC_CTRL, SRC_CONST} rtcseq_src_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_PWRON_CHECK, OP_TIME_WRITE, OP_TIME_READ,
    OP_PERIODIC_ON, OP_ALARM_SET, OP_ALARM_CANCEL, OP_AUTO_READ
  } rtcseq_op_t;

  typedef enum {ST_WAIT_PWR, ST_IDLE, ST_SETUP, ST_CMD, ST_DATA, ST_HOLD, ST_GAP} rtcseq_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic        rd;
    logic [3:0]  cnt;
    rtcseq_src_t src;
    logic [3:0]  base;
    logic [7:0]  andMask;
    logic [7:0]  orMask;
    logic [7:0]  constByte;
    logic        last;
  } rtcseq_frame_t;

endpackage

/* File: rtcseq_sync2.sv */
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module rtcseq_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] async,
  input  wire logic [W-1:0] resetLevel,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= resetLevel;
      sync <= resetLevel;
    end else if (clkEn) begin
      meta <= async;
      sync <= meta;
    end
  end
endmodule // rtcseq_sync2

/* File: rtcseq_shifter.sv */
// byte shifter: drives the serial clock and data out, samples data in
`timescale 1ns/1ps
module rtcseq_shifter #(
  parameter int HALF_CYC = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  input  wire logic       soBit,
  output logic            sclk,
  output logic            si,
  output logic            done,
  output logic [7:0]      rxByte
);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYC - 1);

  logic          active;
  logic [HW-1:0] halfCnt;
  logic [2:0]    bitCnt;
  logic [7:0]    sh;

  generate
    if (HALF_CYC < 3) begin : g_bad_half
      $error("HALF_CYC must be at least 3 to cover the input synchroniser");
    end
  endgenerate

  // ------------------------------------------------------------
  // msb first; si set up in the low half, so sampled at the end of the high half
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active  <= 1'b0;
      halfCnt <= '0;
      bitCnt  <= 3'h0;
      sh      <= 8'h00;
      sclk    <= 1'b0;
      si      <= 1'b0;
      done    <= 1'b0;
      rxByte  <= 8'h00;
    end else if (clkEn) begin
      done <= 1'b0;
      if (!active) begin
        if (start) begin
          active  <= 1'b1;
          sh      <= txByte;
          si      <= txByte[7];
          halfCnt <= '0;
          bitCnt  <= 3'h0;
          sclk    <= 1'b0;
        end
      end else if (halfCnt == HALF_LAST) begin
        halfCnt <= '0;
        if (!sclk) begin
          sclk <= 1'b1;
        end else begin
          sclk   <= 1'b0;
          rxByte <= {rxByte[6:0], soBit};
          if (bitCnt == 3'h7) begin
            active <= 1'b0;
            done   <= 1'b1;
          end else begin
            bitCnt <= bitCnt + 3'h1;
            sh     <= {sh[6:0], 1'b0};
            si     <= sh[6];
          end
        end
      end else begin
        halfCnt <= halfCnt + HW'(1);
      end
    end
  end
endmodule // rtcseq_shifter

/* File: rtcseq_host.sv */
// host sequencer for a four-wire serial real-time clock, programmed over apb
//
// Summary of operation
// - wait two seconds after power-up before access
// - after seconds write, clear supply-drop flag once
// - select held across whole seconds-to-year write
// - select held across whole seconds-to-year read
// - select level mode; read within one second
// - clear periodic flag; device withdraws interrupt
// - full read first after write, subset later
// - clear alarm enables before changing alarm
// - set enables only after alarm fully written
// - cancel alarm with fixed weekly/daily patterns
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module rtcseq_host
  import rtcseq_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES    = POWERUP_CYC,
  parameter int unsigned READ_LIMIT_CYCLES = READ_LIMIT_CYC,
  parameter int          SCLK_HALF         = SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             chipEnable,
  output logic             serialClk,
  output logic             serialOut,
  input  wire logic        serialIn,
  input  wire logic        interruptPin_b
);

  generate
    if (POWERUP_CYCLES < 1 || READ_LIMIT_CYCLES < 1 || SCLK_HALF < 3) begin : g_bad_param
      $error("cycle counts must be at least one and SCLK_HALF at least 3");
    end
  endgenerate

  localparam logic [31:0] HALF_LAST = 32'(SCLK_HALF - 1);
  localparam logic [31:0] PWR_LAST  = 32'(POWERUP_CYCLES - 1);
  localparam logic [31:0] LATE_LIM  = 32'(READ_LIMIT_CYCLES);

  rtcseq_state_t  state;
  rtcseq_op_t     op;
  rtcseq_op_t     pendOp;
  rtcseq_op_t     next_op;
  rtcseq_frame_t  cur;
  rtcseq_frame_t  startFrame;
  rtcseq_frame_t  stepFrame;
  logic [2:0]     step;
  logic [3:0]     idx;
  logic [31:0]    waitCnt;
  logic [31:0]    lateCnt;
  logic [7:0]     ctrlByte;
  logic [7:0]     buffer [BUF_WORDS];
  logic [CFG_W-1:0] cfg;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] evPulse;
  logic           pwronFlag;
  logic           powered;
  logic           firstReadPend;
  logic           shStart;
  logic [7:0]     shTx;
  logic           shDone;
  logic [7:0]     shRx;
  logic [1:0]     pinSync;
  logic           soSync;
  logic           intLow;
  logic           halfDone;
  logic           cmdTake;
  logic [3:0]     txIdx;
  logic [7:0]     next_tx;
  logic           accessCyc;
  logic           apbWr;
  logic [5:0]     bufIdx;
  logic           bufHit;
  logic           addrOk;
  logic [31:0]    rdData;

  // ----------------------------------------------------------------
  // pins and shifter
  // ----------------------------------------------------------------
  rtcseq_sync2 #(.W(2)) u_sync (
    .clk        (clk),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .async      ({serialIn, interruptPin_b}),
    .resetLevel (2'h1),
    .sync       (pinSync)
  );
  assign soSync = pinSync[1];
  assign intLow = ~pinSync[0];

  rtcseq_shifter #(.HALF_CYC(SCLK_HALF)) u_shift (
    .clk    (clk),
    .rst_b  (rst_b),
    .clkEn  (clkEn),
    .start  (shStart),
    .txByte (shTx),
    .soBit  (soSync),
    .sclk   (serialClk),
    .si     (serialOut),
    .done   (shDone),
    .rxByte (shRx)
  );

  // ----------------------------------------------------------------
  // frame list of each operation
  // ----------------------------------------------------------------
  function automatic rtcseq_frame_t frameOf(rtcseq_op_t o, logic [2:0] s, logic mon, logic subset,
                                            logic first, logic wen, logic den);
    rtcseq_frame_t f;
    f = '{addr: DEV_ADDR_CTRL1, rd: 1'b1, cnt: 4'h1, src: SRC_CTRL, base: 4'h0,
          andMask: 8'hff, orMask: 8'h00, constByte: 8'h00, last: 1'b0};
    case (o)
      OP_PWRON_CHECK: f.last = 1'b1;
      OP_TIME_WRITE: begin
        if (s == 3'h0) begin
          f = '{DEV_ADDR_SEC, 1'b0, 4'(TIME_BYTES), SRC_BUF, BUF_TIME, 8'hff, 8'h00, 8'h00, !mon};
        end else begin
          f.addr = DEV_ADDR_CTRL2;
          f.rd = (s == 3'h1);
          f.andMask = ~CTRL2_DROP_MASK;
          f.last = (s == 3'h2);
        end
      end
      OP_TIME_READ: f = '{DEV_ADDR_SEC, 1'b1, 4'(TIME_BYTES), SRC_BUF, BUF_TIME, 8'hff, 8'h00, 8'h00, 1'b1};
      OP_PERIODIC_ON: begin
        f.rd = (s == 3'h0);
        f.andMask = ~CTRL1_PSEL_MASK;
        f.orMask = CTRL1_PSEL_LVL1S;
        f.last = (s == 3'h1);
      end
      OP_AUTO_READ: begin
        if (s == 3'h0) begin
          f = '{DEV_ADDR_SEC, 1'b1, (first || !subset) ? 4'(TIME_BYTES) : 4'(SUBSET_BYTES),
                SRC_BUF, BUF_TIME, 8'hff, 8'h00, 8'h00, 1'b0};
        end else begin
          f.addr = DEV_ADDR_CTRL2;
          f.rd = (s == 3'h1);
          f.andMask = ~CTRL2_PIRQ_MASK;
          f.last = (s == 3'h2);
        end
      end
      OP_ALARM_SET, OP_ALARM_CANCEL: begin
        f.rd = (s == 3'h0);
        f.andMask = ~CTRL1_EN_MASK;
        if (s == 3'h2 || s == 3'h3) begin
          f.addr = (s == 3'h2) ? DEV_ADDR_ALW : DEV_ADDR_ALD;
          f.cnt = (s == 3'h2) ? 4'(ALW_BYTES) : 4'(ALD_BYTES);
          f.base = (s == 3'h2) ? BUF_ALW : BUF_ALD;
          f.src = (o == OP_ALARM_SET) ? SRC_BUF : SRC_CONST;
          f.constByte = (s == 3'h2) ? ALW_CANCEL : ALD_CANCEL;
          f.last = (o == OP_ALARM_CANCEL) && (s == 3'h3);
        end else if (s == 3'h4) begin
          f.orMask = 8'({wen, den}) << CTRL1_DEN_BIT;
          f.last = 1'b1;
        end
      end
      default: f.last = 1'b1;
    endcase
    return f;
  endfunction

  always_comb begin
    next_op = OP_NONE;
    if (state == ST_IDLE) begin
      if (cfg[CFG_AUTO_BIT] && intLow) begin
        next_op = OP_AUTO_READ;
      end else if (pendOp != OP_NONE) begin
        next_op = pendOp;
      end
    end
  end

  assign cmdTake    = (state == ST_IDLE) && (next_op != OP_NONE) && (next_op != OP_AUTO_READ);
  assign startFrame = frameOf(next_op, 3'h0, cfg[CFG_MON_BIT], cfg[CFG_SUBSET_BIT], firstReadPend,
                              cfg[CFG_WEN_BIT], cfg[CFG_DEN_BIT]);
  assign stepFrame  = frameOf(op, step + 3'h1, cfg[CFG_MON_BIT], cfg[CFG_SUBSET_BIT], firstReadPend,
                              cfg[CFG_WEN_BIT], cfg[CFG_DEN_BIT]);
  assign halfDone   = (waitCnt == HALF_LAST);
  assign txIdx      = (state == ST_CMD) ? 4'h0 : idx + 4'h1;

  always_comb begin
    next_tx = 8'h00;
    if (!cur.rd) begin
      case (cur.src)
        SRC_BUF:   next_tx = buffer[cur.base + txIdx];
        SRC_CTRL:  next_tx = (ctrlByte & cur.andMask) | cur.orMask;
        SRC_CONST: next_tx = cur.constByte;
        default:   next_tx = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer: frames framed by chip enable, bytes through the shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state         <= ST_WAIT_PWR;
      op            <= OP_NONE;
      cur           <= '0;
      step          <= 3'h0;
      idx           <= 4'h0;
      waitCnt       <= 32'h0;
      lateCnt       <= 32'h0;
      ctrlByte      <= 8'h00;
      chipEnable    <= 1'b0;
      shStart       <= 1'b0;
      shTx          <= 8'h00;
      evPulse       <= '0;
      pwronFlag     <= 1'b0;
      powered       <= 1'b0;
      firstReadPend <= 1'b1;
    end else if (clkEn) begin
      shStart <= 1'b0;
      evPulse <= '0;
      if (lateCnt != 32'hffff_ffff) begin
        lateCnt <= lateCnt + 32'h1;
      end
      case (state)
        ST_WAIT_PWR: begin
          if (waitCnt == PWR_LAST) begin
            waitCnt <= 32'h0;
            powered <= 1'b1;
            op      <= OP_PWRON_CHECK;
            step    <= 3'h0;
            cur     <= frameOf(OP_PWRON_CHECK, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            state   <= ST_SETUP;
          end else begin
            waitCnt <= waitCnt + 32'h1;
          end
        end
        ST_IDLE: begin
          if (next_op != OP_NONE) begin
            op      <= next_op;
            step    <= 3'h0;
            cur     <= startFrame;
            lateCnt <= 32'h0;
            waitCnt <= 32'h0;
            state   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          chipEnable <= 1'b1;
          if (halfDone) begin
            waitCnt <= 32'h0;
            shStart <= 1'b1;
            shTx    <= {cur.addr, cur.rd ? DEV_MODE_RD : DEV_MODE_WR};
            state   <= ST_CMD;
          end else begin
            waitCnt <= waitCnt + 32'h1;
          end
        end
        ST_CMD, ST_DATA: begin
          if (shDone) begin
            if (state == ST_DATA && cur.rd && cur.src == SRC_CTRL) begin
              ctrlByte <= shRx;
            end
            if (state == ST_DATA && idx == cur.cnt - 4'h1) begin
              state <= ST_HOLD;
            end else begin
              idx     <= txIdx;
              shStart <= 1'b1;
              shTx    <= next_tx;
              state   <= ST_DATA;
            end
          end
        end
        ST_HOLD: begin
          if (halfDone) begin
            waitCnt    <= 32'h0;
            chipEnable <= 1'b0;
            state      <= ST_GAP;
          end else begin
            waitCnt <= waitCnt + 32'h1;
          end
        end
        ST_GAP: begin
          if (halfDone) begin
            waitCnt <= 32'h0;
            idx     <= 4'h0;
            if (op == OP_PWRON_CHECK) begin
              pwronFlag             <= ctrlByte[CTRL1_PWRON_BIT];
              evPulse[IRQ_INIT_BIT] <= ctrlByte[CTRL1_PWRON_BIT];
            end
            if (op == OP_AUTO_READ && step == 3'h0) begin
              evPulse[IRQ_LATE_BIT] <= (lateCnt >= LATE_LIM);
              firstReadPend         <= 1'b0;
            end
            if (op == OP_TIME_WRITE && step == 3'h0) begin
              firstReadPend <= 1'b1;
            end
            if (cur.last) begin
              evPulse[IRQ_DONE_BIT] <= (op != OP_AUTO_READ);
              evPulse[IRQ_AUTO_BIT] <= (op == OP_AUTO_READ);
              op    <= OP_NONE;
              state <= ST_IDLE;
            end else begin
              step  <= step + 3'h1;
              cur   <= stepFrame;
              state <= ST_SETUP;
            end
          end else begin
            waitCnt <= waitCnt + 32'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb slave: two-cycle access phase, pready from a flop
  // ----------------------------------------------------------------
  assign accessCyc = psel & penable & ~pready;
  assign apbWr     = psel & penable & pready & pwrite;
  assign bufIdx    = 6'(paddr[7:2] - OFF_BUF[7:2]);
  assign bufHit    = (paddr >= OFF_BUF) && (bufIdx < 6'(BUF_WORDS));
  assign addrOk    = (paddr[1:0] == 2'h0) && (bufHit || paddr == OFF_CMD || paddr == OFF_CFG ||
                     paddr == OFF_STATUS || paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK);

  always_comb begin
    rdData = 32'h0;
    if (bufHit) begin
      rdData = {24'h0, buffer[bufIdx[3:0]]};
    end else begin
      case (paddr)
        OFF_CFG:      rdData = 32'(cfg);
        OFF_IRQ_STAT: rdData = 32'(irqStat);
        OFF_IRQ_MASK: rdData = 32'(irqMask);
        OFF_STATUS: begin
          rdData[ST_BUSY_BIT]  = (state != ST_IDLE) || (pendOp != OP_NONE);
          rdData[ST_READY_BIT] = powered;
          rdData[ST_PWRON_BIT] = pwronFlag;
          rdData[ST_FIRST_BIT] = firstReadPend;
        end
        default: rdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      cfg     <= CFG_RESET;
      irqMask <= IRQ_RESET;
      pendOp  <= OP_NONE;
    end else if (clkEn) begin
      pready  <= accessCyc;
      pslverr <= accessCyc & ~addrOk;
      if (accessCyc) begin
        prdata <= pwrite ? 32'h0 : rdData;
      end
      if (cmdTake) begin
        pendOp <= OP_NONE;
      end
      if (apbWr && addrOk) begin
        if (paddr == OFF_CFG) begin
          cfg <= pwdata[CFG_W-1:0];
        end
        if (paddr == OFF_IRQ_MASK) begin
          irqMask <= pwdata[IRQ_W-1:0];
        end
        if (paddr == OFF_CMD && pendOp == OP_NONE && state == ST_IDLE) begin
          case (pwdata[2:0])
            CMD_TIME_WRITE:   pendOp <= OP_TIME_WRITE;
            CMD_TIME_READ:    pendOp <= OP_TIME_READ;
            CMD_PERIODIC_ON:  pendOp <= OP_PERIODIC_ON;
            CMD_ALARM_SET:    pendOp <= OP_ALARM_SET;
            CMD_ALARM_CANCEL: pendOp <= OP_ALARM_CANCEL;
            default:          pendOp <= OP_NONE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // data buffer: read bursts land here, software fills it while idle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buffer[i] <= 8'h00;
      end
    end else if (clkEn) begin
      if (state == ST_DATA && shDone && cur.rd && cur.src == SRC_BUF) begin
        buffer[cur.base + idx] <= shRx;
      end else if (apbWr && bufHit && paddr[1:0] == 2'h0 && state == ST_IDLE) begin
        buffer[bufIdx[3:0]] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: write one to clear, a new event wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqStat <= IRQ_RESET;
      irq     <= 1'b0;
    end else if (clkEn) begin
      irqStat <= (irqStat & ~((apbWr && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : IRQ_RESET)) | evPulse;
      irq     <= |(irqStat & irqMask);
    end
  end

endmodule // rtcseq_host

/* File: rtcseq_dev.sv */
// behavioural model of the serial clock device
`timescale 1ns/1ps
module rtcseq_dev #(parameter int PER = 3000) (
  input  wire logic clk,
  input  wire logic ce,
  input  wire logic sck,
  input  wire logic si,
  output logic      so,
  output logic      intPin_b
);
  logic [7:0] mem [16];
  logic [7:0] sh;
  logic [3:0] a, md;
  int         bc, frac;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[14] = 8'h10; // power-on flag from zero volts
    mem[15] = 8'h40;
    so = 1'b0;
    frac = 0;
  end
  assign intPin_b = ~mem[15][2]; // low until flag written 0
  always @(posedge ce) bc = 0;
  always @(negedge ce) so <= ~so;
  always @(posedge sck) begin
    sh = {sh[6:0], si};
    bc++;
    if (bc == 8) {a, md} = sh;
    else if (bc % 8 == 0) begin
      if (md == 4'h0) mem[a] = sh;
      if (md == 4'h0 && a == 4'h0) frac = 0; // sub-second restart
      a++;
    end
  end
  always @(negedge sck) if (bc >= 8 && md == 4'h4) so <= mem[a][7 - bc % 8];
  always @(posedge clk) begin
    frac++;
    if (frac >= PER) begin
      frac = 0;
      mem[0]++;
      if (mem[14][2:0] == 3'h4) mem[15][2] = 1'b1; // tick with seconds
    end
  end
endmodule // rtcseq_dev

/* File: rtcseq_host_sva.sv */
// port assertions of the host sequencer
`timescale 1ns/1ps
module rtcseq_host_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chipEnable,
  input wire logic serialClk,
  input wire logic serialOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_pwr; $rose(rst_b) |-> !chipEnable [*8]; endproperty
  a_pwr: assert property (p_pwr) else $error("select raised in power-up wait");
  property p_sel; serialClk |-> chipEnable; endproperty
  a_sel: assert property (p_sel) else $error("serial clock outside frame");
  property p_gap; $fell(chipEnable) |-> (!chipEnable && !serialClk) [*3]; endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");
  property p_lead; $rose(chipEnable) |-> !serialClk [*3]; endproperty
  a_lead: assert property (p_lead) else $error("clock too soon after select");
  property p_half; $rose(serialClk) |-> serialClk [*3]; endproperty
  a_half: assert property (p_half) else $error("short clock high half");
  property p_so; serialClk && $past(serialClk) |-> $stable(serialOut); endproperty
  a_so: assert property (p_so) else $error("data moved in high half");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than a cycle");
  property p_acc; pready |-> $past(psel && penable); endproperty
  a_acc: assert property (p_acc) else $error("ready without access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule // rtcseq_host_chk
bind rtcseq_host rtcseq_host_chk u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .chipEnable(chipEnable), .serialClk(serialClk), .serialOut(serialOut));

/* File: rtcseq_host_tb.sv */
// self-checking bench of the host sequencer
`timescale 1ns/1ps
module rtcseq_host_tb;
  import rtcseq_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, ce, sck, so, si, pin_b, er, en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  rtcseq_host #(.POWERUP_CYCLES(200), .READ_LIMIT_CYCLES(5000), .SCLK_HALF(4)) uut (.clk(clk), .rst_b(rst_b),
    .clkEn(en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .chipEnable(ce), .serialClk(sck),
    .serialOut(si), .serialIn(so), .interruptPin_b(pin_b));
  rtcseq_dev dev (.clk(clk), .ce(ce), .sck(sck), .si(si), .so(so), .intPin_b(pin_b));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 80000) begin
    n_mismatch++;
    wrap_up;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task cmd(input logic [2:0] c);
    apb(1, OFF_CMD, {29'h0, c});
    do apb(0, OFF_IRQ_STAT, 0); while (rd[IRQ_DONE_BIT] !== 1'b1);
    apb(1, OFF_IRQ_STAT, 32'h1);
  endtask
  task t_pwr;
    do apb(0, OFF_STATUS, 0); while (rd[1:0] !== 2'b10);
    chk("pwron", 1'b1, rd[ST_PWRON_BIT]);
    apb(0, OFF_IRQ_STAT, 0);
    chk("init", 1'b1, rd[IRQ_INIT_BIT]);
    apb(1, OFF_IRQ_STAT, 32'hf);
    $display("t_pwr done");
  endtask
  task t_time;
    for (int i = 0; i < 7; i++) apb(1, OFF_BUF + 8'(4 * i), 32'h10 + i);
    apb(1, OFF_CFG, 32'h1);
    cmd(CMD_TIME_WRITE);
    for (int i = 0; i < 7; i++) chk("time", 8'h10 + i, dev.mem[i]);
    chk("drop", 1'b0, dev.mem[15][6]);
    dev.mem[3] = 8'h99;
    cmd(CMD_TIME_READ);
    apb(0, OFF_BUF + 8'hc, 0);
    chk("rd", 8'h99, rd);
    $display("t_time done");
  endtask
  task t_alarm;
    apb(1, OFF_CFG, 32'h18);
    for (int i = 7; i < 12; i++) apb(1, OFF_BUF + 8'(4 * i), 32'ha0 + i);
    cmd(CMD_ALARM_SET);
    for (int i = 7; i < 12; i++) chk("alarm", 8'ha0 + i, dev.mem[i + 1]);
    chk("en", 2'b11, dev.mem[14][7:6]);
    cmd(CMD_ALARM_CANCEL);
    chk("cw", 8'h55, dev.mem[10]);
    chk("cd", 8'h56, dev.mem[12]);
    chk("dis", 2'b00, dev.mem[14][7:6]);
    $display("t_alarm done");
  endtask
  task t_irq;
    apb(0, 8'h14, 0);
    chk("err", 1'b1, er);
    apb(1, OFF_IRQ_MASK, 32'h4);
    apb(1, OFF_CFG, 32'h2);
    cmd(CMD_PERIODIC_ON);
    chk("psel", 3'h4, dev.mem[14][2:0]);
    while (irq !== 1'b1) @(posedge clk);
    chk("flag", 1'b0, dev.mem[15][2]);
    chk("pin", 1'b1, pin_b);
    apb(1, OFF_IRQ_MASK, 0);
    repeat (3) @(posedge clk);
    chk("mask", 1'b0, irq);
    apb(1, OFF_IRQ_STAT, 32'hf);
    apb(0, OFF_IRQ_STAT, 0);
    chk("clr", 1'b0, rd[IRQ_AUTO_BIT]);
    $display("t_irq done");
  endtask
  initial begin
    rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; en = 1;
    repeat (20) @(posedge clk);
    rst_b <= 1;
    en <= 0;
    repeat (250) @(posedge clk);
    chk("freeze", 1'b0, ce);
    en <= 1;
    t_pwr;
    t_time;
    t_alarm;
    t_irq;
    wrap_up;
  end
endmodule // rtcseq_host_tb
